// ### hsm_pkg.sv
// Package: constants, register map and state types of the monitor pin control block
// Behaviour
// - Low address strap sets the least significant programmable slave address bit.
// - High address strap sets the most significant programmable slave address bit.
// - In chain test mode the low strap pin drives the NAND chain result.
// - Test-enable pin high selects NAND chain test mode; low means normal operation.
// - Outside test mode the test-enable pin serves as the analogue level output.
// - High level on the intrusion line is recorded as a sticky intrusion event.
// - Either intrusion clear bit pulls the intrusion line low for at least 20 ms.
// - Interrupt pin drives only while the enable bit is one; it resets to zero.
// - Enabled then triggered reset output pulls the reset pin low for 20 ms.
// - Reset pin pulled low by the board acts as master reset.
// - While the board holds the reset pin low all registers return to defaults.
// - Unmasked out-of-limit status bits assert the interrupt, subject to the enable.
package hsm_pkg;

  // Clock and pulse timing
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned PULSE_MS         = 20;
  localparam int unsigned MS_PER_S         = 1000;
  localparam int unsigned PULSE_CYCLES_DEF = PULSE_MS * (CLK_HZ / MS_PER_S);
  localparam int unsigned CNT_W            = 19;

  // Register indices; byte address is four times the index
  localparam int unsigned IDX_W         = 8;
  localparam int unsigned ADDR_LSB      = 2;
  localparam int unsigned ADDR_TOP      = ADDR_LSB + IDX_W;
  localparam logic [7:0]  IDX_CFG       = 8'h40;
  localparam logic [7:0]  IDX_INT_STAT1 = 8'h41;
  localparam logic [7:0]  IDX_INT_STAT2 = 8'h42;
  localparam logic [7:0]  IDX_INT_MASK  = 8'h43;
  localparam logic [7:0]  IDX_RST_CTL   = 8'h44;
  localparam logic [7:0]  IDX_PIN_STAT  = 8'h45;
  localparam logic [7:0]  IDX_CHASSIS   = 8'h46;
  localparam logic [7:0]  IDX_DAC       = 8'h47;

  // Field positions
  localparam int unsigned CFG_INT_EN_BIT  = 1;
  localparam int unsigned CFG_RST_GO_BIT  = 4;
  localparam int unsigned CFG_CI_CLR_BIT  = 6;
  localparam int unsigned RST_CTL_EN_BIT  = 7;
  localparam int unsigned CHS_CI_CLR_BIT  = 7;
  localparam int unsigned STAT2_CI_BIT    = 0;
  localparam int unsigned PSTAT_TEST_BIT  = 2;
  localparam int unsigned PSTAT_RST_BIT   = 3;
  localparam int unsigned PSTAT_CI_BIT    = 4;

  // Reset values
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] RST_CTL_RST = 8'h00;
  localparam logic [7:0] CHS_RST     = 8'h00;
  localparam logic [7:0] STAT_RST    = 8'h00;
  localparam logic [7:0] DAC_RST     = 8'h00;

  // Synchronised pin vector layout
  localparam int unsigned NAND_W       = 8;
  localparam int unsigned PIN_STRAP_LO = 0;
  localparam int unsigned PIN_STRAP_HI = 1;
  localparam int unsigned PIN_TEST     = 2;
  localparam int unsigned PIN_RST      = 3;
  localparam int unsigned PIN_CI       = 4;
  localparam int unsigned PIN_CHAIN    = 5;
  localparam int unsigned PIN_W        = PIN_CHAIN + NAND_W;
  localparam int unsigned HIST_W       = 3;

  localparam logic       HRESP_OKAY = 1'b0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Bus request carrier
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } hsm_ahb_req_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} hsm_bus_st_t;

  typedef struct packed {
    hsm_bus_st_t       bus;
    logic [7:0]        idx;
    logic              mapped;
    logic [31:0]       rdata;
    logic [PIN_W-1:0]  sync1;
    logic [PIN_W-1:0]  sync2;
    logic [HIST_W-1:0] drv_hist;
    logic              test_mode;
    logic [1:0]        slave_addr;
    logic              chain;
    logic              int_act;
    logic [7:0]        cfg;
    logic [7:0]        mask;
    logic [7:0]        rst_ctl;
    logic [7:0]        chassis;
    logic [7:0]        stat1;
    logic [7:0]        stat2;
    logic [7:0]        dac;
  } hsm_state_t;

  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] cnt;
  } hsm_tmr_state_t;

  // NAND tree: each stage NANDs one pin with the previous stage output
  function automatic logic nand_tree(input logic [NAND_W-1:0] pins);
    logic acc;
    acc = 1'b1;
    for (int i = 0; i < NAND_W; i++)
    begin
      acc = ~(pins[i] & acc);
    end
    return acc;
  endfunction

endpackage

// ### hsm_pulse_timer.sv
// Module: minimum-width low pulse timer for the open-drain outputs
`timescale 1ns/1ps
module hsm_pulse_timer #(
  parameter int unsigned CYCLES = hsm_pkg::PULSE_CYCLES_DEF
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic start_i,
  output logic      busy_o
);

  localparam logic [hsm_pkg::CNT_W-1:0] LAST = hsm_pkg::CNT_W'(CYCLES - 1);
  localparam logic [hsm_pkg::CNT_W-1:0] ONE  = hsm_pkg::CNT_W'(1);

  hsm_pkg::hsm_tmr_state_t s_q;
  hsm_pkg::hsm_tmr_state_t s_d;

  // A new trigger restarts the count, so a retrigger stretches the pulse
  always_comb
  begin
    s_d = s_q;
    if (start_i)
    begin
      s_d.busy = 1'b1;
      s_d.cnt  = '0;
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt == LAST)
        s_d.busy = 1'b0;
      else
        s_d.cnt = s_q.cnt + ONE;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign busy_o = s_q.busy;

  // Pulse width checks
  chk_pulse_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(s_q.busy) |-> s_q.cnt == '0)
    else $error("pulse timer did not start from zero");
  chk_pulse_width: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(s_q.busy) && !$past(start_i) |-> $past(s_q.cnt) == LAST)
    else $error("pulse ended before its minimum width");

endmodule

// ### hsm_pin_ctrl.sv
// Module: pin control logic of the monitor with its AHB-Lite register slave
`timescale 1ns/1ps
module hsm_pin_ctrl #(
  parameter int unsigned PULSE_CYCLES = hsm_pkg::PULSE_CYCLES_DEF
) (
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire hsm_pkg::hsm_ahb_req_t       ahb_req_i,
  output logic [31:0]                      hrdata_o,
  output logic                             hreadyout_o,
  output logic                             hresp_o,
  input  wire logic                        addr_strap_low_i,
  output logic                             addr_strap_low_o,
  output logic                             addr_strap_low_oe_n_o,
  input  wire logic                        addr_strap_high_i,
  input  wire logic                        chain_test_enable_in_i,
  input  wire logic [hsm_pkg::NAND_W-1:0]  chain_pins_i,
  output logic [7:0]                       analog_level_out_o,
  output logic                             analog_level_oe_n_o,
  input  wire logic                        intrusion_detect_line_i,
  output logic                             intrusion_detect_line_o,
  output logic                             intrusion_detect_line_oe_n_o,
  input  wire logic                        reset_pin_i,
  output logic                             reset_pin_o,
  output logic                             reset_pin_oe_n_o,
  output logic                             int_pin_o,
  output logic                             int_pin_oe_n_o,
  input  wire logic [7:0]                  limit_flags_i,
  output logic [1:0]                       slave_addr_o
);

  hsm_pkg::hsm_state_t s_q;
  hsm_pkg::hsm_state_t s_d;

  logic                    rst_busy;
  logic                    ci_busy;
  logic                    master_rst;
  logic                    tmr_rst_n;
  logic                    take;
  logic                    wr_en;
  logic [7:0]              wdat;
  logic                    wr_cfg;
  logic                    wr_chs;
  logic                    start_rst;
  logic                    start_ci;
  logic [hsm_pkg::PIN_W-1:0] pins;

  // Decode of a word index; used in the address phase, its result kept for the read mux
  function automatic logic is_mapped(input logic [7:0] idx);
    return idx inside {hsm_pkg::IDX_CFG, hsm_pkg::IDX_INT_STAT1, hsm_pkg::IDX_INT_STAT2,
                       hsm_pkg::IDX_INT_MASK, hsm_pkg::IDX_RST_CTL, hsm_pkg::IDX_PIN_STAT,
                       hsm_pkg::IDX_CHASSIS, hsm_pkg::IDX_DAC};
  endfunction

  // Read view; trigger bits read back as pulse in progress
  function automatic logic [7:0] read_reg(input logic [7:0] idx);
    logic [7:0] v;
    v = '0;
    case (idx)
      hsm_pkg::IDX_CFG:
      begin
        v = s_q.cfg;
        v[hsm_pkg::CFG_RST_GO_BIT] = rst_busy;
        v[hsm_pkg::CFG_CI_CLR_BIT] = ci_busy;
      end
      hsm_pkg::IDX_INT_STAT1: v = s_q.stat1;
      hsm_pkg::IDX_INT_STAT2: v = s_q.stat2;
      hsm_pkg::IDX_INT_MASK:  v = s_q.mask;
      hsm_pkg::IDX_RST_CTL:   v = s_q.rst_ctl;
      hsm_pkg::IDX_PIN_STAT:
      begin
        v[1:0] = s_q.slave_addr;
        v[hsm_pkg::PSTAT_TEST_BIT] = s_q.test_mode;
        v[hsm_pkg::PSTAT_RST_BIT]  = rst_busy;
        v[hsm_pkg::PSTAT_CI_BIT]   = s_q.sync2[hsm_pkg::PIN_CI];
      end
      hsm_pkg::IDX_CHASSIS:
      begin
        v = s_q.chassis;
        v[hsm_pkg::CHS_CI_CLR_BIT] = ci_busy;
      end
      hsm_pkg::IDX_DAC:       v = s_q.dac;
      default:                v = '0;
    endcase
    return v;
  endfunction

  // Default register contents, shared by both reset sources
  function automatic hsm_pkg::hsm_state_t rst_state();
    hsm_pkg::hsm_state_t r;
    r         = '0;
    r.bus     = hsm_pkg::BUS_IDLE;
    // Reset pin idles high; a zero here would fake a board reset on release
    r.sync1[hsm_pkg::PIN_RST] = 1'b1;
    r.sync2[hsm_pkg::PIN_RST] = 1'b1;
    r.cfg     = hsm_pkg::CFG_RST;
    r.mask    = hsm_pkg::MASK_RST;
    r.rst_ctl = hsm_pkg::RST_CTL_RST;
    r.chassis = hsm_pkg::CHS_RST;
    r.stat1   = hsm_pkg::STAT_RST;
    r.stat2   = hsm_pkg::STAT_RST;
    r.dac     = hsm_pkg::DAC_RST;
    return r;
  endfunction

  // Raw pins gathered for the two-flop synchroniser
  assign pins = {chain_pins_i, intrusion_detect_line_i, reset_pin_i, chain_test_enable_in_i,
                 addr_strap_high_i, addr_strap_low_i};

  // Own reset pulse reads back low on the pin; history masks it through sync latency
  assign master_rst = !s_q.sync2[hsm_pkg::PIN_RST] && !rst_busy && (s_q.drv_hist == '0);
  assign tmr_rst_n  = reset_n_i && !master_rst;

  // Main next-state logic
  always_comb
  begin
    s_d       = s_q;
    take      = ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hready;
    wr_en     = (s_q.bus == hsm_pkg::BUS_WRITE) && s_q.mapped;
    wdat      = ahb_req_i.hwdata[7:0];
    wr_cfg    = wr_en && (s_q.idx == hsm_pkg::IDX_CFG);
    wr_chs    = wr_en && (s_q.idx == hsm_pkg::IDX_CHASSIS);
    start_rst = wr_cfg && wdat[hsm_pkg::CFG_RST_GO_BIT] && s_q.rst_ctl[hsm_pkg::RST_CTL_EN_BIT];
    start_ci  = (wr_cfg && wdat[hsm_pkg::CFG_CI_CLR_BIT])
             || (wr_chs && wdat[hsm_pkg::CHS_CI_CLR_BIT]);

    // Pin synchronisers and own-drive history
    s_d.sync1    = pins;
    s_d.sync2    = s_q.sync1;
    s_d.drv_hist = {s_q.drv_hist[hsm_pkg::HIST_W-2:0], rst_busy};

    // Test mode and address straps; address frozen while the low strap is an output
    s_d.test_mode = s_q.sync2[hsm_pkg::PIN_TEST];
    if (!s_q.sync2[hsm_pkg::PIN_TEST])
    begin
      s_d.slave_addr[0] = s_q.sync2[hsm_pkg::PIN_STRAP_LO];
      s_d.slave_addr[1] = s_q.sync2[hsm_pkg::PIN_STRAP_HI];
    end
    s_d.chain = hsm_pkg::nand_tree(s_q.sync2[hsm_pkg::PIN_CHAIN +: hsm_pkg::NAND_W]);

    // Bus phases: writes take no wait, reads take one to build hrdata
    case (s_q.bus)
      hsm_pkg::BUS_READ_WAIT:
      begin
        s_d.rdata = {24'h000000, s_q.mapped ? read_reg(s_q.idx) : 8'h00};
        s_d.bus   = hsm_pkg::BUS_READ_DONE;
      end
      hsm_pkg::BUS_IDLE, hsm_pkg::BUS_WRITE, hsm_pkg::BUS_READ_DONE:
      begin
        if (take)
        begin
          s_d.idx    = ahb_req_i.haddr[hsm_pkg::ADDR_TOP-1:hsm_pkg::ADDR_LSB];
          s_d.mapped = is_mapped(ahb_req_i.haddr[hsm_pkg::ADDR_TOP-1:hsm_pkg::ADDR_LSB])
                    && (ahb_req_i.haddr[31:hsm_pkg::ADDR_TOP] == '0);
          s_d.bus    = ahb_req_i.hwrite ? hsm_pkg::BUS_WRITE : hsm_pkg::BUS_READ_WAIT;
        end
        else
          s_d.bus = hsm_pkg::BUS_IDLE;
      end
      default: s_d.bus = hsm_pkg::BUS_IDLE;
    endcase

    // Register writes; trigger bits are not stored, they start the timers
    if (wr_cfg)
    begin
      s_d.cfg = wdat;
      s_d.cfg[hsm_pkg::CFG_RST_GO_BIT] = 1'b0;
      s_d.cfg[hsm_pkg::CFG_CI_CLR_BIT] = 1'b0;
    end
    if (wr_chs)
    begin
      s_d.chassis = wdat;
      s_d.chassis[hsm_pkg::CHS_CI_CLR_BIT] = 1'b0;
    end
    if (wr_en && s_q.idx == hsm_pkg::IDX_INT_MASK)
      s_d.mask = wdat;
    if (wr_en && s_q.idx == hsm_pkg::IDX_RST_CTL)
      s_d.rst_ctl = wdat;
    if (wr_en && s_q.idx == hsm_pkg::IDX_DAC)
      s_d.dac = wdat;

    // Sticky status, write one to clear; a new event beats the clear
    s_d.stat1 = s_q.stat1 & ~((wr_en && s_q.idx == hsm_pkg::IDX_INT_STAT1) ? wdat : 8'h00);
    s_d.stat1 = s_d.stat1 | limit_flags_i;
    s_d.stat2 = s_q.stat2 & ~((wr_en && s_q.idx == hsm_pkg::IDX_INT_STAT2) ? wdat : 8'h00);
    s_d.stat2[hsm_pkg::STAT2_CI_BIT] = s_d.stat2[hsm_pkg::STAT2_CI_BIT]
                                     | s_q.sync2[hsm_pkg::PIN_CI];

    // Interrupt drive: enable bit gates any unmasked status
    s_d.int_act = s_q.cfg[hsm_pkg::CFG_INT_EN_BIT]
               && ((|(s_q.stat1 & ~s_q.mask)) || (|s_q.stat2));

    // External reset wipes registers but keeps synchronisers running
    if (master_rst)
    begin
      s_d          = rst_state();
      s_d.sync1    = pins;
      s_d.sync2    = s_q.sync1;
      s_d.drv_hist = s_q.drv_hist;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      s_q <= rst_state();
    else
      s_q <= s_d;
  end

  // Pulse timers for the reset pin and the intrusion clear
  hsm_pulse_timer #(
    .CYCLES (PULSE_CYCLES)
  ) u_rst_tmr (
    .clk_i     (clk_i),
    .reset_n_i (tmr_rst_n),
    .start_i   (start_rst),
    .busy_o    (rst_busy)
  );

  hsm_pulse_timer #(
    .CYCLES (PULSE_CYCLES)
  ) u_ci_tmr (
    .clk_i     (clk_i),
    .reset_n_i (tmr_rst_n),
    .start_i   (start_ci),
    .busy_o    (ci_busy)
  );

  // Bus answers
  assign hrdata_o    = s_q.rdata;
  assign hreadyout_o = (s_q.bus != hsm_pkg::BUS_READ_WAIT);
  assign hresp_o     = hsm_pkg::HRESP_OKAY;

  // Open-drain pins always drive low when enabled
  assign reset_pin_o             = 1'b0;
  assign reset_pin_oe_n_o        = !rst_busy;
  assign intrusion_detect_line_o = 1'b0;
  assign intrusion_detect_line_oe_n_o = !ci_busy;
  assign int_pin_o               = 1'b0;
  assign int_pin_oe_n_o          = !s_q.int_act;

  // Shared test pin and low strap pin
  assign addr_strap_low_o      = s_q.chain;
  assign addr_strap_low_oe_n_o = !s_q.test_mode;
  assign analog_level_out_o    = s_q.dac;
  assign analog_level_oe_n_o   = s_q.test_mode;
  assign slave_addr_o          = s_q.slave_addr;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_addr_low_bit: assert property (
    (!chain_test_enable_in_i && addr_strap_low_i) [*5] |-> slave_addr_o[0])
    else $error("low strap not reflected in slave address");
  chk_addr_high_bit: assert property (
    (!chain_test_enable_in_i && !addr_strap_high_i) [*5] |-> !slave_addr_o[1])
    else $error("high strap not reflected in slave address");
  chk_test_drive: assert property (
    chain_test_enable_in_i [*4] |-> !addr_strap_low_oe_n_o && analog_level_oe_n_o)
    else $error("test mode did not take over the strap pin");
  chk_analog_out: assert property (
    !chain_test_enable_in_i [*4] |-> !analog_level_oe_n_o && addr_strap_low_oe_n_o)
    else $error("analogue output not enabled in normal mode");
  chk_intrusion_set: assert property (
    s_q.sync2[hsm_pkg::PIN_CI] && !master_rst |=> s_q.stat2[hsm_pkg::STAT2_CI_BIT])
    else $error("intrusion event not recorded");
  chk_int_gate: assert property (
    !int_pin_oe_n_o |-> $past(s_q.cfg[hsm_pkg::CFG_INT_EN_BIT]))
    else $error("interrupt driven while disabled");
  chk_int_mask: assert property (
    s_q.cfg[hsm_pkg::CFG_INT_EN_BIT] && |(s_q.stat1 & ~s_q.mask) && !master_rst
      |=> !int_pin_oe_n_o)
    else $error("unmasked status did not assert interrupt");
  chk_ci_clear: assert property (
    start_ci && !master_rst |=> !intrusion_detect_line_oe_n_o [*2])
    else $error("intrusion clear pulse not driven");
  chk_rst_enable: assert property (
    $rose(rst_busy) |-> $past(s_q.rst_ctl[hsm_pkg::RST_CTL_EN_BIT]))
    else $error("reset pulse without enable");
  chk_master_reset: assert property (
    master_rst |=> s_q.cfg == hsm_pkg::CFG_RST && s_q.mask == hsm_pkg::MASK_RST
                && s_q.rst_ctl == hsm_pkg::RST_CTL_RST && int_pin_oe_n_o)
    else $error("external reset did not restore defaults");

  cov_rst_pulse:  cover property ($fell(rst_busy));
  cov_ci_pulse:   cover property ($fell(ci_busy));
  cov_int_active: cover property ($fell(int_pin_oe_n_o));
  cov_test_mode:  cover property ($rose(s_q.test_mode));

endmodule

// ### hsm_board_model.sv
// Board model: pull-ups, strap resistor and external intrusion latch
`timescale 1ns/1ps
module hsm_board_model (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic tamper_i,
  input  wire logic board_rst_low_i,
  input  wire logic strap_low_set_i,
  input  wire logic strap_oe_n_i,
  input  wire logic strap_drv_i,
  input  wire logic ci_oe_n_i,
  input  wire logic ci_drv_i,
  input  wire logic rst_oe_n_i,
  input  wire logic rst_drv_i,
  input  wire logic int_oe_n_i,
  input  wire logic int_drv_i,
  output logic      strap_line_o,
  output logic      ci_line_o,
  output logic      rst_line_o,
  output logic      int_line_o
);
  logic latch_q;

  // Intrusion latch: set by tampering, cleared only while the line is pulled low
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      latch_q <= 1'b0;
    else if (tamper_i)
      latch_q <= 1'b1;
    else if (ci_oe_n_i == 1'b0)
      latch_q <= 1'b0;
  end

  // Wire levels; the device wins over the strap resistor when it drives
  assign strap_line_o = strap_oe_n_i ? strap_low_set_i : strap_drv_i;
  assign ci_line_o    = ci_oe_n_i ? latch_q : ci_drv_i;
  // Pull-up on reset; either party may pull it low
  assign rst_line_o   = (rst_oe_n_i ? 1'b1 : rst_drv_i) & ~board_rst_low_i;
  assign int_line_o   = int_oe_n_i ? 1'b1 : int_drv_i;
endmodule

// ### testbench.sv
// Testbench: pin control block with board model and bus master tasks
`timescale 1ns/1ps
module testbench;
  localparam int P = 10;
  logic clk_i, reset_n_i, tamper, brst, strap_lo, strap_hi, test_en;
  logic [7:0] pins, flags;
  logic strap_line, ci_line, rst_line, int_line;
  logic strap_o, strap_oe_n, ci_o, ci_oe_n, rst_o, rst_oe_n, int_o, int_oe_n, aoe_n, hrdy, hresp;
  logic [7:0] analog_level_out;
  logic [1:0] saddr;
  logic [31:0] hrdata, rd;
  hsm_pkg::hsm_ahb_req_t req, ahb_req;
  int n_fail, checks;

  // Bus hready is the slave's own hreadyout
  always_comb
  begin
    ahb_req = req;
    ahb_req.hready = hrdy;
  end

  hsm_pin_ctrl #(.PULSE_CYCLES(P)) hsm_pin_ctrl_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ahb_req_i(ahb_req), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .addr_strap_low_i(strap_line),
    .addr_strap_low_o(strap_o), .addr_strap_low_oe_n_o(strap_oe_n),
    .addr_strap_high_i(strap_hi), .chain_test_enable_in_i(test_en), .chain_pins_i(pins),
    .analog_level_out_o(analog_level_out), .analog_level_oe_n_o(aoe_n), .intrusion_detect_line_i(ci_line),
    .intrusion_detect_line_o(ci_o), .intrusion_detect_line_oe_n_o(ci_oe_n),
    .reset_pin_i(rst_line), .reset_pin_o(rst_o), .reset_pin_oe_n_o(rst_oe_n),
    .int_pin_o(int_o), .int_pin_oe_n_o(int_oe_n), .limit_flags_i(flags), .slave_addr_o(saddr));

  hsm_board_model hsm_board_model_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .tamper_i(tamper), .board_rst_low_i(brst),
    .strap_low_set_i(strap_lo),
    .strap_oe_n_i(strap_oe_n), .strap_drv_i(strap_o), .ci_oe_n_i(ci_oe_n), .ci_drv_i(ci_o),
    .rst_oe_n_i(rst_oe_n), .rst_drv_i(rst_o), .int_oe_n_i(int_oe_n), .int_drv_i(int_o),
    .strap_line_o(strap_line), .ci_line_o(ci_line), .rst_line_o(rst_line),
    .int_line_o(int_line));

  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] adr(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk_i);
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.htrans <= 2'h2;
    req.hwrite <= wr;
    req.hsize <= hsm_pkg::HSIZE_WORD;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= {24'h0, d};
    do @(posedge clk_i); while (hrdy !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, hsm_pkg::HRESP_OKAY}, "resp");
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string m);
    bus(adr(idx), 1'b0, 8'h00);
    chk(rd, {24'h0, exp}, m);
  endtask

  // Length of the next low pulse, zero if none within 50 cycles
  // Intrusion line idles low once the latch clears, so its drive enable is timed
  task automatic pulse(input logic on_ci, input int exp, input string m);
    int w, n;
    w = 0;
    n = 0;
    do @(posedge clk_i); while ((on_ci ? ci_oe_n : rst_line) !== 1'b0 && ++w < 50);
    while ((on_ci ? ci_oe_n : rst_line) === 1'b0 && n < 1000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n, exp, m);
  endtask

  task automatic t_reset_vals;
    rd_chk(hsm_pkg::IDX_CFG, hsm_pkg::CFG_RST, "cfg rst");
    rd_chk(hsm_pkg::IDX_RST_CTL, hsm_pkg::RST_CTL_RST, "rstctl rst");
    rd_chk(8'h00, 8'h00, "unmapped");
    chk(int_line, 1'b1, "int idle");
    chk(aoe_n, 1'b0, "analog_level_out oe");
    $display("test reset_vals done");
  endtask

  task automatic t_straps;
    for (int k = 0; k < 4; k++)
    begin
      strap_lo <= k[0];
      strap_hi <= k[1];
      repeat (5) @(posedge clk_i);
      chk(saddr, k[1:0], "strap");
      rd_chk(hsm_pkg::IDX_PIN_STAT, {6'h0, k[1:0]}, "pinstat");
    end
    $display("test straps done");
  endtask

  task automatic t_test_mode;
    logic [7:0] v [3] = '{8'hff, 8'h00, 8'h2b};
    logic e;
    strap_lo <= 1'b0;
    bus(adr(hsm_pkg::IDX_DAC), 1'b1, 8'h5a);
    @(posedge clk_i);
    chk(analog_level_out, 8'h5a, "dac");
    test_en <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      pins <= v[k];
      repeat (5) @(posedge clk_i);
      e = 1'b1;
      for (int i = 0; i < 8; i++)
        e = ~(v[k][i] & e);
      chk(strap_oe_n, 1'b0, "chain oe");
      chk(strap_line, e, "chain out");
      chk(aoe_n, 1'b1, "analog_level_out off");
    end
    test_en <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(strap_oe_n, 1'b1, "strap in");
    chk(aoe_n, 1'b0, "analog_level_out on");
    $display("test test_mode done");
  endtask

  task automatic t_intrusion;
    @(posedge clk_i) tamper <= 1'b1;
    @(posedge clk_i) tamper <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd_chk(hsm_pkg::IDX_INT_STAT2, 8'h01, "ci stat");
    rd_chk(hsm_pkg::IDX_PIN_STAT, 8'h12, "ci level");
    bus(adr(hsm_pkg::IDX_CHASSIS), 1'b1, 8'h80);
    pulse(1'b1, P, "ci clr 46");
    bus(adr(hsm_pkg::IDX_CFG), 1'b1, 8'h40);
    pulse(1'b1, P, "ci clr 40");
    bus(adr(hsm_pkg::IDX_INT_STAT2), 1'b1, 8'h01);
    rd_chk(hsm_pkg::IDX_INT_STAT2, 8'h00, "ci w1c");
    $display("test intrusion done");
  endtask

  task automatic t_int;
    @(posedge clk_i) flags <= 8'h01;
    @(posedge clk_i) flags <= 8'h00;
    repeat (4) @(posedge clk_i);
    chk(int_line, 1'b1, "int off");
    bus(adr(hsm_pkg::IDX_INT_MASK), 1'b1, 8'h01);
    bus(adr(hsm_pkg::IDX_CFG), 1'b1, 8'h02);
    repeat (3) @(posedge clk_i);
    chk(int_line, 1'b1, "int masked");
    bus(adr(hsm_pkg::IDX_INT_MASK), 1'b1, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(int_line, 1'b0, "int on");
    bus(adr(hsm_pkg::IDX_INT_STAT1), 1'b1, 8'h01);
    repeat (3) @(posedge clk_i);
    chk(int_line, 1'b1, "int w1c");
    $display("test int done");
  endtask

  task automatic t_rst_pulse;
    bus(adr(hsm_pkg::IDX_CFG), 1'b1, 8'h10);
    pulse(1'b0, 0, "rst disabled");
    bus(adr(hsm_pkg::IDX_RST_CTL), 1'b1, 8'h80);
    bus(adr(hsm_pkg::IDX_CFG), 1'b1, 8'h10);
    pulse(1'b0, P, "rst pulse");
    rd_chk(hsm_pkg::IDX_RST_CTL, 8'h80, "own pulse");
    $display("test rst_pulse done");
  endtask

  task automatic t_ext_reset;
    bus(adr(hsm_pkg::IDX_CFG), 1'b1, 8'h02);
    @(posedge clk_i) brst <= 1'b1;
    repeat (8) @(posedge clk_i);
    brst <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(hsm_pkg::IDX_CFG, 8'h00, "ext cfg");
    rd_chk(hsm_pkg::IDX_DAC, 8'h00, "ext dac");
    rd_chk(hsm_pkg::IDX_RST_CTL, 8'h00, "ext rstctl");
    $display("test ext_reset done");
  endtask

  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("MISMATCH t=%0t watchdog", $time);
    stop_test();
  end

  // Main sequence
  initial
  begin
    n_fail = 0;
    checks = 0;
    req = '0;
    reset_n_i = 1'b0;
    tamper = 1'b0;
    brst = 1'b0;
    strap_lo = 1'b0;
    strap_hi = 1'b0;
    test_en = 1'b0;
    pins = 8'h00;
    flags = 8'h00;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset_vals();
    t_straps();
    t_test_mode();
    t_intrusion();
    t_int();
    t_rst_pulse();
    t_ext_reset();
    stop_test();
  end
endmodule
